/* hw/csc_pkg.sv */
// constants and types shared by the sideband control block
package csc_pkg;
   localparam int          CSC_SYNC_STAGES    = 2;       // depth of each input synchroniser
   localparam int          CSC_RESET_RELEASE  = 2;       // bus clocks allowed to release outputs
   localparam logic        CSC_LAPIC_EN_RST   = 1'b1;    // local interrupt controller on after reset
   localparam logic        CSC_NATIVE_FPU_RST = 1'b0;    // native numeric error mode off after reset
   localparam logic [1:0]  CSC_SNOOP_IDLE     = 2'h0;    // hit / modified both idle
   localparam logic [1:0]  CSC_SNOOP_STALL    = 2'h3;    // hit and modified together
   localparam logic [1:0]  CSC_SNOOP_HIT      = 2'h1;    // clean hit
   localparam logic [1:0]  CSC_SNOOP_SNOOP_MODIFIED_RESULT     = 2'h2;    // modified hit
   localparam int          CSC_LINT_MASKABLE  = 0;       // pin position of maskable request
   localparam int          CSC_LINT_NONMASK   = 1;       // pin position of nonmaskable request

   // lock sequencer states
   typedef enum logic [2:0] {
      CSC_LK_IDLE = 3'b001,
      CSC_LK_HOLD = 3'b010,
      CSC_LK_DONE = 3'b100
   } csc_lock_t;
endpackage

/* hw/csc_sync.sv */
// two-stage synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module csc_sync
   import csc_pkg::*;
#(
   parameter int WIDTH = 1                   // number of bits synchronised
) (
   input  wire logic             clk_in,     // bus clock
   input  wire logic             rst_n_in,   // asynchronous reset, active low
   input  wire logic [WIDTH-1:0] async_in,   // raw asynchronous levels
   output logic      [WIDTH-1:0] sync_out    // levels retimed to the bus clock
);
   // state: first and second flop stages
   typedef struct packed {
      logic [WIDTH-1:0] meta;                // first stage, read only by the second
      logic [WIDTH-1:0] stab;                // second stage, safe to use
   } csc_sync_t;

   csc_sync_t st_reg;
   csc_sync_t st_next;

   // next state: shift the raw level in
   always_comb begin
      st_next      = st_reg;
      st_next.meta = async_in;
      st_next.stab = st_reg.meta;
   end

   // register state, cleared under reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stab;
endmodule
`default_nettype wire

/* hw/csc_top.sv */
// sideband control and status logic of the processor bus interface
`timescale 1ns/1ps
`default_nettype none
// Operation
// - both snoop lines together mean stall
// - internal error raises fault indicator and halt
// - fault held until reset, restart or init
// - ignore input active: skip pending numeric error
// - ignore inactive: pending error raises exception
// - native numeric mode disables ignore input
// - soft init resets integers, restarts at vector
// - snoops keep being serviced during soft init
// - init at reset release requests self-test
// - controller off: pins become maskable, nonmaskable
// - local interrupt controller enabled after reset
// - lock held first start to last end
// - outputs released within two clocks of reset
module csc_top
   import csc_pkg::*;
(
   input  wire logic       clk_in,                  // bus clock, 25 MHz
   input  wire logic       rst_n_in,                // hard reset, asynchronous, active low
   // snoop result lines, active low on the wire, open drain
   input  wire logic       snoop_hit_n_in,          // hit line level seen on the bus
   input  wire logic       snoop_modified_result_n_in, // modified line level seen on the bus
   input  wire logic       snoop_req_in,            // core asks to drive a snoop result
   input  wire logic [1:0] snoop_result_in,         // result code from the core
   output logic            snoop_hit_oe_out,        // pull hit line low
   output logic            snoop_modified_result_oe_out, // pull modified line low
   output logic            snoop_stall_seen_out,    // some agent signals snoop stall
   output logic            snoop_service_out,       // snoop logic is active
   // fault reporting
   input  wire logic       internal_error_in,       // core detected an internal error
   input  wire logic       bus_restart_n_in,        // bus restart input, active low
   output logic            fault_indicator_n_out,   // fault indicator, active low
   output logic            halt_on_fault_cycle_out, // one-cycle request for a halt cycle
   // numeric error control
   input  wire logic       numeric_fault_ignore_n_in, // ignore numeric error, active low, async
   input  wire logic       fpu_error_native_mode_in, // native mode bit of control_reg_zero
   input  wire logic       fpu_error_pending_in,    // earlier fp instruction faulted
   input  wire logic       fpu_noncontrol_op_in,    // noncontrol fp instruction issued
   output logic            fpu_exception_out,       // raise numeric exception, one cycle
   output logic            fpu_continue_out,        // proceed with the instruction, one cycle
   // soft initialisation and self-test
   input  wire logic       soft_init_n_in,          // soft init, active low, async
   output logic            int_reg_reset_out,       // clear integer registers, one cycle
   output logic            vector_restart_out,      // fetch from reset vector, one cycle
   output logic            self_test_req_out,       // run built-in self-test, one cycle
   // local interrupt pins
   input  wire logic [1:0] local_irq_pins_in,       // local interrupt pins, async
   input  wire logic       lapic_disable_in,        // software turns controller off
   output logic            lapic_enabled_out,       // controller currently on
   output logic [1:0]      local_irq_out,           // pins routed to the controller
   output logic            maskable_irq_req_out,    // maskable request, controller off
   output logic            nonmask_irq_out,         // nonmaskable request, controller off
   // locked sequences
   input  wire logic       lock_start_in,           // first transaction of locked run begins
   input  wire logic       lock_last_end_in,        // last transaction of locked run ends
   input  wire logic       priority_agent_request_n_in, // priority agent request, active low
   output logic            atomic_lock_n_out,       // atomic sequence, active low
   output logic            priority_grant_ok_out    // priority agent may take the bus
);
   // all block state
   typedef struct packed {
      logic      hit_oe;
      logic      snoop_modified_result_oe;
      logic      stall_seen;
      logic      snoop_svc;
      logic      fault;
      logic      halt;
      logic      fexc;
      logic      fcont;
      logic      int_rst;
      logic      vec_rst;
      logic      bist;
      logic      init_prev;                    // last synchronised soft init level
      logic      first;                        // strap window still open after reset release
      logic [1:0] strap_cnt;                   // cycles since release, until synchroniser filled
      logic      fault_n;                      // registered copy of the fault pin level
      logic      lock_n;                       // registered copy of the lock pin level
      logic      lapic_en;
      logic [1:0] lirq;
      logic      mirq;
      logic      nmi;
      csc_lock_t lock_st;
      logic      grant_ok;
   } csc_state_t;

   csc_state_t st_reg;
   csc_state_t st_next;

   logic       ignore_act;                     // ignore numeric error, high true
   logic       init_act;                       // soft init, high true
   logic [1:0] lint_s;                         // synchronised interrupt pins

   // asynchronous levels retimed before any use
   csc_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in ({local_irq_pins_in, ~soft_init_n_in, ~numeric_fault_ignore_n_in}),
      .sync_out ({lint_s, init_act, ignore_act})
   );

   // next-state logic for every sideband function
   always_comb begin
      st_next = st_reg;
      // snoop: drive a result or a stall, watch the bus for a stall
      st_next.hit_oe  = snoop_req_in && snoop_result_in[0];
      st_next.snoop_modified_result_oe = snoop_req_in && snoop_result_in[1];
      st_next.stall_seen = !snoop_hit_n_in && !snoop_modified_result_n_in;
      // snoop logic stays up even while soft init holds the core
      st_next.snoop_svc = 1'b1;
      // fault indicator: set wins over any clear in the same cycle
      if (internal_error_in) begin
         st_next.fault = 1'b1;
      end else if (!bus_restart_n_in || init_act) begin
         st_next.fault = 1'b0;
      end
      // halt cycle issued once on the rising edge of the fault
      st_next.halt = internal_error_in && !st_reg.fault;
      // numeric error handling, ignore input gated off in native mode
      st_next.fexc  = 1'b0;
      st_next.fcont = 1'b0;
      if (fpu_noncontrol_op_in) begin
         if (fpu_error_pending_in && (fpu_error_native_mode_in || !ignore_act)) begin
            st_next.fexc = 1'b1;
         end else begin
            st_next.fcont = 1'b1;
         end
      end
      // soft init: act on the asserting edge only, so a long init gives one restart
      st_next.init_prev = init_act;
      st_next.int_rst   = init_act && !st_reg.init_prev;
      st_next.vec_rst   = init_act && !st_reg.init_prev;
      // self-test strap: the synchroniser is cleared by reset, so the init level
      // only becomes visible once it has refilled; the strap is judged then, once
      if (st_reg.strap_cnt != 2'(CSC_SYNC_STAGES)) begin
         st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      end
      st_next.first = st_reg.first && (st_reg.strap_cnt != 2'(CSC_SYNC_STAGES));
      st_next.bist  = st_reg.first && (st_reg.strap_cnt == 2'(CSC_SYNC_STAGES))
                      && init_act;
      // local interrupt controller enable, software may turn it off
      st_next.lapic_en = !lapic_disable_in;
      if (st_reg.lapic_en) begin
         st_next.lirq = lint_s;
         st_next.mirq = 1'b0;
         st_next.nmi  = 1'b0;
      end else begin
         st_next.lirq = 2'h0;
         st_next.mirq = lint_s[CSC_LINT_MASKABLE];
         st_next.nmi  = lint_s[CSC_LINT_NONMASK];
      end
      // lock sequencer
      case (st_reg.lock_st)
         CSC_LK_IDLE: begin
            if (lock_start_in) begin
               st_next.lock_st = CSC_LK_HOLD;
            end
         end
         CSC_LK_HOLD: begin
            if (lock_last_end_in) begin
               st_next.lock_st = CSC_LK_DONE;
            end
         end
         CSC_LK_DONE: begin
            st_next.lock_st = CSC_LK_IDLE;
         end
         default: begin
            st_next.lock_st = CSC_LK_IDLE;
         end
      endcase
      // priority agent only proceeds while no lock is held
      st_next.grant_ok = !priority_agent_request_n_in
                         && (st_next.lock_st != CSC_LK_HOLD);
      // pin levels kept in flops so the active-low outputs need no gate
      st_next.lock_n  = (st_next.lock_st != CSC_LK_HOLD);
      st_next.fault_n = !st_next.fault;
   end

   // register state; reset clears every driver at once, well inside two clocks
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg          <= '0;
         st_reg.first    <= 1'b1;
         st_reg.lapic_en <= CSC_LAPIC_EN_RST;
         st_reg.lock_st  <= CSC_LK_IDLE;
         st_reg.lock_n   <= 1'b1;
         st_reg.fault_n  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs, straight from flops
   assign snoop_hit_oe_out             = st_reg.hit_oe;
   assign snoop_modified_result_oe_out = st_reg.snoop_modified_result_oe;
   assign snoop_stall_seen_out         = st_reg.stall_seen;
   assign snoop_service_out            = st_reg.snoop_svc;
   assign fault_indicator_n_out        = st_reg.fault_n;
   assign halt_on_fault_cycle_out      = st_reg.halt;
   assign fpu_exception_out            = st_reg.fexc;
   assign fpu_continue_out             = st_reg.fcont;
   assign int_reg_reset_out            = st_reg.int_rst;
   assign vector_restart_out           = st_reg.vec_rst;
   assign self_test_req_out            = st_reg.bist;
   assign lapic_enabled_out            = st_reg.lapic_en;
   assign local_irq_out                = st_reg.lirq;
   assign maskable_irq_req_out         = st_reg.mirq;
   assign nonmask_irq_out              = st_reg.nmi;
   assign atomic_lock_n_out            = st_reg.lock_n;
   assign priority_grant_ok_out        = st_reg.grant_ok;
endmodule
`default_nettype wire

/* bench/csc_assertions.sv */
// concurrent checks on the sideband control block ports
`timescale 1ns/1ps
`default_nettype none
module csc_assertions
   import csc_pkg::*;
(
   input wire logic       clk_in, rst_n_in, snoop_hit_n_in, snoop_modified_result_n_in,
   input wire logic       snoop_req_in, snoop_hit_oe_out, snoop_modified_result_oe_out,
   input wire logic [1:0] snoop_result_in,
   input wire logic       snoop_stall_seen_out, snoop_service_out, soft_init_n_in,
   input wire logic       internal_error_in, bus_restart_n_in, fault_indicator_n_out,
   input wire logic       halt_on_fault_cycle_out, fpu_noncontrol_op_in, fpu_error_pending_in,
   input wire logic       fpu_error_native_mode_in, fpu_exception_out, fpu_continue_out,
   input wire logic       lapic_disable_in, lapic_enabled_out, lock_start_in, lock_last_end_in,
   input wire logic       atomic_lock_n_out, priority_grant_ok_out
);
   // one clock domain, so clock and reset are declared once
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_stall_seen: assert property (!snoop_hit_n_in && !snoop_modified_result_n_in |=>
      snoop_stall_seen_out) else $error("stall not flagged");
   a_snoop_drive: assert property (snoop_req_in |=> {snoop_modified_result_oe_out,
      snoop_hit_oe_out} == $past(snoop_result_in)) else $error("snoop code wrong");
   a_fault_set: assert property (internal_error_in |=> !fault_indicator_n_out)
      else $error("fault not raised");
   a_halt_pulse: assert property ($rose(halt_on_fault_cycle_out) |-> !fault_indicator_n_out
      ##1 !halt_on_fault_cycle_out) else $error("halt pulse wrong");
   // init reaches the logic three cycles late, so its recent past must be quiet too
   a_fault_hold: assert property (!fault_indicator_n_out && bus_restart_n_in && soft_init_n_in
      && $past(soft_init_n_in) && $past(soft_init_n_in, 2) && $past(soft_init_n_in, 3)
      |=> !fault_indicator_n_out) else $error("fault dropped");
   a_fpu_native: assert property (fpu_noncontrol_op_in && fpu_error_pending_in &&
      fpu_error_native_mode_in |=> fpu_exception_out && !fpu_continue_out)
      else $error("native mode ignored");
   a_init_snoop: assert property (!soft_init_n_in && $past(rst_n_in) |-> snoop_service_out)
      else $error("snoops stopped in init");
   a_lapic_off: assert property (lapic_disable_in |=> !lapic_enabled_out)
      else $error("controller still on");
   a_lock_set: assert property (lock_start_in |=> !atomic_lock_n_out)
      else $error("lock not taken");
   a_lock_keep: assert property (!atomic_lock_n_out && !lock_last_end_in |=>
      !atomic_lock_n_out) else $error("lock dropped early");
   a_lock_free: assert property (!atomic_lock_n_out && lock_last_end_in |=>
      atomic_lock_n_out) else $error("lock not freed");
   a_grant_lock: assert property (priority_grant_ok_out |-> atomic_lock_n_out)
      else $error("grant during lock");
   c_lock_end: cover property (lock_last_end_in && !atomic_lock_n_out);
   c_fault_clr: cover property (!fault_indicator_n_out && !bus_restart_n_in);
   c_stall: cover property (snoop_stall_seen_out);
endmodule
bind csc_top csc_assertions csc_assertions_inst (.clk_in, .rst_n_in, .snoop_hit_n_in,
   .snoop_modified_result_n_in, .snoop_req_in, .snoop_hit_oe_out,
   .snoop_modified_result_oe_out, .snoop_result_in, .snoop_stall_seen_out,
   .snoop_service_out, .soft_init_n_in, .internal_error_in, .bus_restart_n_in,
   .fault_indicator_n_out, .halt_on_fault_cycle_out, .fpu_noncontrol_op_in,
   .fpu_error_pending_in, .fpu_error_native_mode_in, .fpu_exception_out, .fpu_continue_out,
   .lapic_disable_in, .lapic_enabled_out, .lock_start_in, .lock_last_end_in,
   .atomic_lock_n_out, .priority_grant_ok_out);
`default_nettype wire

/* bench/csc_partner.sv */
// chipset side model: snoop stall pulls and priority agent
`timescale 1ns/1ps
`default_nettype none
module csc_partner (
   input  wire logic clk_in,            // bus clock
   input  wire logic stall_cmd_in,      // bench asks for a stall cycle
   input  wire logic want_bus_in,       // bench asks for ownership
   input  wire logic atomic_lock_n_in,  // lock level on the bus
   output logic      pull_hit_out,      // pull hit line low
   output logic      pull_modified_out, // pull modified line low
   output logic      pri_req_n_out,     // priority request, active low
   output logic      owns_bus_out       // model holds the bus
);
   // a stall always pulls both lines; holding the command repeats it
   assign pull_hit_out      = stall_cmd_in;
   assign pull_modified_out = stall_cmd_in;
   assign pri_req_n_out     = !want_bus_in;
   // ownership waits for the lock release, so a locked run stays atomic
   always_ff @(posedge clk_in) begin
      owns_bus_out <= want_bus_in && atomic_lock_n_in;
   end
endmodule
`default_nettype wire

/* bench/csc_tb.sv */
// self-checking bench for the sideband control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import csc_pkg::*;
   logic clk_in = 1'b0, rst_n_in = 1'b0, snoop_req_in = 1'b0, internal_error_in = 1'b0;
   logic bus_restart_n_in = 1'b1, numeric_fault_ignore_n_in = 1'b1, soft_init_n_in = 1'b1;
   logic fpu_error_native_mode_in = 1'b0, fpu_error_pending_in = 1'b0, lock_start_in = 1'b0;
   logic fpu_noncontrol_op_in = 1'b0, lapic_disable_in = 1'b0, lock_last_end_in = 1'b0;
   logic stall_cmd = 1'b0, want_bus = 1'b0, pull_h, pull_m, owns, seen;
   logic [1:0] snoop_result_in = 2'h0, local_irq_pins_in = 2'h0, local_irq_out;
   logic snoop_hit_oe_out, snoop_modified_result_oe_out, snoop_stall_seen_out;
   logic snoop_service_out, fault_indicator_n_out, halt_on_fault_cycle_out, fpu_exception_out;
   logic fpu_continue_out, int_reg_reset_out, vector_restart_out, self_test_req_out;
   logic lapic_enabled_out, maskable_irq_req_out, nonmask_irq_out, atomic_lock_n_out;
   logic priority_grant_ok_out, priority_agent_request_n_in;
   wire  snoop_hit_n_in = !(snoop_hit_oe_out | pull_h);  // pulled-up shared lines
   wire  snoop_modified_result_n_in = !(snoop_modified_result_oe_out | pull_m);
   int   num_errors = 0, checked = 0;
   always #20 clk_in = ~clk_in;
   csc_top csc_top_inst (.clk_in, .rst_n_in, .snoop_hit_n_in, .snoop_modified_result_n_in,
      .snoop_req_in, .snoop_result_in, .snoop_hit_oe_out, .snoop_modified_result_oe_out,
      .snoop_stall_seen_out, .snoop_service_out, .internal_error_in, .bus_restart_n_in,
      .fault_indicator_n_out, .halt_on_fault_cycle_out, .numeric_fault_ignore_n_in,
      .fpu_error_native_mode_in, .fpu_error_pending_in, .fpu_noncontrol_op_in,
      .fpu_exception_out, .fpu_continue_out, .soft_init_n_in, .int_reg_reset_out,
      .vector_restart_out, .self_test_req_out, .local_irq_pins_in, .lapic_disable_in,
      .lapic_enabled_out, .local_irq_out, .maskable_irq_req_out, .nonmask_irq_out,
      .lock_start_in, .lock_last_end_in, .priority_agent_request_n_in, .atomic_lock_n_out,
      .priority_grant_ok_out);
   csc_partner csc_partner_inst (.clk_in, .stall_cmd_in(stall_cmd), .want_bus_in(want_bus),
      .atomic_lock_n_in(atomic_lock_n_out), .pull_hit_out(pull_h), .pull_modified_out(pull_m),
      .pri_req_n_out(priority_agent_request_n_in), .owns_bus_out(owns));
   // compare and count; case equality keeps unknowns from matching
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // stops at a rising edge so the caller drives with non-blocking assignment
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic t_snoop();
      for (int c = 0; c < 4; c++) begin
         tick(1); snoop_req_in <= 1'b1; snoop_result_in <= 2'(c);
         tick(1); snoop_req_in <= 1'b0;
         #1 chk("snoop_oe", 2'(c), {snoop_modified_result_oe_out, snoop_hit_oe_out});
      end
      tick(1); stall_cmd <= 1'b1;
      tick(2); stall_cmd <= 1'b0;
      #1 chk("stall_seen", 2'h1, snoop_stall_seen_out);
   endtask
   task automatic t_fault();
      tick(1); internal_error_in <= 1'b1;
      tick(1); internal_error_in <= 1'b0;
      #1 chk("fault_halt", 2'h1, {fault_indicator_n_out, halt_on_fault_cycle_out});
      tick(5); internal_error_in <= 1'b1; bus_restart_n_in <= 1'b0;  // error wins the clear
      tick(1); internal_error_in <= 1'b0; bus_restart_n_in <= 1'b1;
      #1 chk("fault_held", 2'h0, fault_indicator_n_out);
      tick(2); bus_restart_n_in <= 1'b0;
      tick(1); bus_restart_n_in <= 1'b1; internal_error_in <= 1'b1;
      #1 chk("fault_restart", 2'h1, fault_indicator_n_out);
      tick(1); internal_error_in <= 1'b0; soft_init_n_in <= 1'b0;
      tick(3);
      #1 chk("init_fault", 2'h1, fault_indicator_n_out);
      chk("init_pulses", 2'h3, {int_reg_reset_out, vector_restart_out});
      chk("init_snoop", 2'h1, snoop_service_out);
      tick(1); soft_init_n_in <= 1'b1;
      #1 chk("init_once", 2'h0, {int_reg_reset_out, vector_restart_out});
   endtask
   // inputs settle long before the op, as the far side must arrange for async levels
   task automatic t_fpu();
      for (int i = 0; i < 8; i++) begin
         tick(1); {fpu_error_native_mode_in, fpu_error_pending_in} <= 2'(i >> 1);
         numeric_fault_ignore_n_in <= !i[0];
         tick(4); fpu_noncontrol_op_in <= 1'b1;
         tick(1); fpu_noncontrol_op_in <= 1'b0;
         seen = (i & 2) != 0 && ((i & 4) != 0 || !i[0]);
         #1 chk("fpu_exc_cont", {seen, !seen}, {fpu_exception_out, fpu_continue_out});
      end
   endtask
   task automatic t_lint();
      for (int d = 0; d < 4; d++) begin
         tick(1); lapic_disable_in <= d[1]; local_irq_pins_in <= d[0] ? 2'h1 : 2'h2;
         tick(4);
         #1 chk("lapic_en", 2'(!d[1]), lapic_enabled_out);
         if (d[1]) chk("irq_remap", local_irq_pins_in, {nonmask_irq_out, maskable_irq_req_out});
         else chk("lint_route", local_irq_pins_in, local_irq_out);
      end
      tick(1); lapic_disable_in <= 1'b0;
   endtask
   task automatic t_lock();
      tick(1); want_bus <= 1'b1; lock_start_in <= 1'b1;
      tick(1); lock_start_in <= 1'b0;
      tick(4);
      #1 chk("locked", 2'h0, {priority_grant_ok_out, owns});
      chk("lock_pin", 2'h0, atomic_lock_n_out);
      tick(1); lock_last_end_in <= 1'b1;
      tick(1); lock_last_end_in <= 1'b0;
      #1 chk("unlocked", 2'h1, atomic_lock_n_out);
      tick(2);
      #1 chk("granted", 2'h3, {priority_grant_ok_out, owns});
      tick(1); want_bus <= 1'b0; lock_start_in <= 1'b1;
      snoop_req_in <= 1'b1; snoop_result_in <= 2'h3;
      tick(2); lock_start_in <= 1'b0; snoop_req_in <= 1'b0; rst_n_in <= 1'b0;
      tick(2);
      #1 chk("reset_release", 2'h2, {atomic_lock_n_out, snoop_hit_oe_out});
      chk("reset_oe", 2'h0, snoop_modified_result_oe_out);
   endtask
   // init held low across the reset release asks for self-test
   task automatic t_bist();
      tick(1); soft_init_n_in <= 1'b0;
      tick(3); rst_n_in <= 1'b1;
      seen = 1'b0;
      for (int k = 0; k < 6; k++) begin
         tick(1);
         #1 seen |= self_test_req_out;
      end
      tick(1); soft_init_n_in <= 1'b1;
      chk("self_test", 2'h1, seen);
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard: about eight times the expected run
   initial begin
      #40000;
      num_errors++;
      give_verdict();
   end
   initial begin
      tick(10); rst_n_in <= 1'b1;
      #1 chk("rst_levels", 2'h3, {fault_indicator_n_out, atomic_lock_n_out});
      chk("rst_lapic", 2'h1, lapic_enabled_out);
      t_snoop();
      t_fault();
      t_fpu();
      t_lint();
      t_lock();
      t_bist();
      give_verdict();
   end
endmodule
`default_nettype wire
